// ---- verilog/wws_defs.svh ----
// Timing and layout constants for the windowed watchdog supervisor.
// Assumes a 100 MHz system clock; all watchdog spans derive from one base timeout, the filter count from the reaction time.
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH

// Clock period in ns
`define WWS_CLK_PERIOD_NS 10
// Base timeout in ms, as printed
`define WWS_BASE_TIMEOUT_MS 100
// Base timeout in cycles
`define WWS_BASE_TIMEOUT_CYC ((`WWS_BASE_TIMEOUT_MS * 1000000) / `WWS_CLK_PERIOD_NS)
// Window fraction in percent
`define WWS_WINDOW_PCT 20
// Comparator reaction time in us, typical and longest
`define WWS_REACT_TYP_US 5
`define WWS_REACT_MAX_US 20
// Filter count: typical reaction time in cycles, well inside the longest
`define WWS_REACT_CYC ((`WWS_REACT_TYP_US * 1000) / `WWS_CLK_PERIOD_NS)
// Services needed before enable goes active
`define WWS_SERVICES_NEEDED 3
// Pulse width divisor of the base timeout
`define WWS_PULSE_DIV 40

`endif

// ---- verilog/wws_pkg.sv ----
// Types for the windowed watchdog supervisor.
// Assumes no surrounding context beyond the constant header.
package wws_pkg;
	// Supervisor states, one-hot
	typedef enum logic [4:0] {
		WWS_ST_HOLD = 5'h01,
		WWS_ST_STARTUP = 5'h02,
		WWS_ST_CLOSED = 5'h04,
		WWS_ST_OPEN = 5'h08,
		WWS_ST_PULSE = 5'h10
	} wws_state_e;
endpackage

// ---- verilog/wws_sync.sv ----
// Three-stage synchroniser with agreement check for one pin input.
// Assumes the input may change at any time relative to i_sys_clk.
`timescale 1ns/1ns
`default_nettype none
module wws_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level
);
	logic [2:0] stage_q; // Shift chain; stage 0 feeds only stage 1
	logic [2:0] stage_d;
	logic level_q; // Accepted level
	logic level_d;

	// Next values: a change counts once stages 1 and 2 agree
	always_comb begin
		stage_d = {stage_q[1:0], i_pin};
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end

	// Registers only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_q <= {3{RESET_VAL}};
			level_q <= RESET_VAL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign o_level = level_q;
endmodule // wws_sync
`default_nettype wire

// ---- verilog/wws_supervisor.sv ----
// Windowed watchdog with supply supervisor: state machine and pin drivers.
// Assumes a digital comparator result on i_monitor_above and an external
// pull-up on every open-drain output; one clock, no software registers.
//
// Overview of operation
// - Hold reset while voltage below reference
// - Keep reset one base timeout after crossing
// - Voltage drop always forces reset
// - Filter comparator, react within twenty microseconds
// - Period split into closed then open window
// - Closed window lasts 0.8 base timeout
// - Open window lasts 0.4 base timeout
// - Window fraction fixed at twenty percent
// - Watchdog reset pulse is timeout over forty
// - All spans scale from one time base
// - Reset output is open drain, low only
// - Enable active low, open drain or push-pull
// - Clear pulses are service events
// - Open service restarts; closed service resets
// - Unserviced periods repeat short reset pulses
// - Enable after three consecutive open services
// - Ignore clear during startup and brown-out
`timescale 1ns/1ns
`default_nettype none
`include "wws_defs.svh"
module wws_supervisor #(
	parameter int BASE_CYC = `WWS_BASE_TIMEOUT_CYC, // Base timeout in cycles
	parameter int REACT_CYC = `WWS_REACT_CYC, // Comparator filter in cycles
	parameter bit EN_PUSH_PULL = 1'b0 // 0: open-drain enable, 1: push-pull
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_monitor_above, // Comparator: monitor_voltage above reference
	input wire logic i_watchdog_service_n, // Clear pin, active low
	output logic o_supervisor_hold_n_out, // Reset pin output value (always 0)
	output logic o_supervisor_hold_n_oe, // Reset pin pull-down enable
	output logic o_enable_n_out, // Enable pin output value
	output logic o_enable_n_oe // Enable pin driver enable
);
	// Derived spans, all from the one base count
	localparam int CLOSED_CYC = BASE_CYC - (BASE_CYC * `WWS_WINDOW_PCT) / 100;
	localparam int OPEN_CYC = 2 * ((BASE_CYC * `WWS_WINDOW_PCT) / 100);
	localparam int PULSE_CYC = BASE_CYC / `WWS_PULSE_DIV;
	localparam int CW = $clog2(BASE_CYC + 1);
	localparam int FW = $clog2(REACT_CYC + 1);

	// Refuse spans the counters cannot serve
	initial begin
		if (BASE_CYC < 2 * `WWS_PULSE_DIV || REACT_CYC < 1) begin
			$error("wws_supervisor: base or filter count too small");
		end
	end

	// Synchronised pins
	logic svc_lvl; // Clear input, settled level
	logic mon_lvl; // Comparator, settled level

	wws_sync #(.RESET_VAL(1'b1)) u_sync_svc (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_watchdog_service_n),
		.o_level(svc_lvl)
	);
	wws_sync #(.RESET_VAL(1'b0)) u_sync_mon (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_monitor_above),
		.o_level(mon_lvl)
	);

	// Comparator filter state
	logic above_q; // Filtered: voltage above reference
	logic above_d;
	logic [FW-1:0] flt_q; // Cycles the raw level disagrees with filtered
	logic [FW-1:0] flt_d;

	// Glitch filter: a new level must persist REACT_CYC cycles, which
	// keeps short excursions from resetting the system.
	always_comb begin
		above_d = above_q;
		flt_d = '0;
		if (mon_lvl != above_q) begin
			if (flt_q >= FW'(REACT_CYC - 1)) begin
				above_d = mon_lvl;
			end else begin
				flt_d = flt_q + FW'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			above_q <= 1'b0;
			flt_q <= '0;
		end else begin
			above_q <= above_d;
			flt_q <= flt_d;
		end
	end

	// Service edge detect on the settled level
	logic svc_prev_q; // Previous settled clear level
	logic svc_prev_d;
	logic svc_fall; // One-cycle service event
	assign svc_prev_d = svc_lvl;
	assign svc_fall = svc_prev_q & ~svc_lvl;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			svc_prev_q <= 1'b1;
		end else begin
			svc_prev_q <= svc_prev_d;
		end
	end

	// Main state machine
	wws_pkg::wws_state_e state_q; // Supervisor state
	wws_pkg::wws_state_e state_d;
	logic [CW-1:0] cnt_q; // Cycles spent in current span
	logic [CW-1:0] cnt_d;
	logic [1:0] good_q; // Consecutive open-window services
	logic [1:0] good_d;
	logic en_q; // Enable active
	logic en_d;
	logic hold_q; // Reset output active
	logic hold_d;

	// Next-state logic. The comparator check sits first so a drop wins
	// over every watchdog event.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + CW'(1);
		good_d = good_q;
		en_d = en_q;
		if (!above_q) begin
			state_d = wws_pkg::WWS_ST_HOLD;
			cnt_d = '0;
			good_d = '0;
			en_d = 1'b0;
		end else begin
			case (state_q)
				wws_pkg::WWS_ST_HOLD: begin
					state_d = wws_pkg::WWS_ST_STARTUP;
					cnt_d = '0;
				end
				wws_pkg::WWS_ST_STARTUP: begin
					// Clear pulses ignored here
					if (cnt_q >= CW'(BASE_CYC - 1)) begin
						state_d = wws_pkg::WWS_ST_CLOSED;
						cnt_d = '0;
					end
				end
				wws_pkg::WWS_ST_CLOSED: begin
					if (svc_fall) begin
						state_d = wws_pkg::WWS_ST_PULSE;
						cnt_d = '0;
						good_d = '0;
						en_d = 1'b0;
					end else if (cnt_q >= CW'(CLOSED_CYC - 1)) begin
						state_d = wws_pkg::WWS_ST_OPEN;
						cnt_d = '0;
					end
				end
				wws_pkg::WWS_ST_OPEN: begin
					if (svc_fall) begin
						state_d = wws_pkg::WWS_ST_CLOSED;
						cnt_d = '0;
						if (good_q == 2'(`WWS_SERVICES_NEEDED - 1)) begin
							en_d = 1'b1;
						end else begin
							good_d = good_q + 2'h1;
						end
					end else if (cnt_q >= CW'(OPEN_CYC - 1)) begin
						state_d = wws_pkg::WWS_ST_PULSE;
						cnt_d = '0;
						good_d = '0;
						en_d = 1'b0;
					end
				end
				wws_pkg::WWS_ST_PULSE: begin
					// Services ignored while the pulse is out
					if (cnt_q >= CW'(PULSE_CYC - 1)) begin
						state_d = wws_pkg::WWS_ST_CLOSED;
						cnt_d = '0;
					end
				end
				default: begin
					state_d = wws_pkg::WWS_ST_HOLD;
					cnt_d = '0;
				end
			endcase
		end
		hold_d = (state_d == wws_pkg::WWS_ST_HOLD) || (state_d == wws_pkg::WWS_ST_STARTUP) ||
			(state_d == wws_pkg::WWS_ST_PULSE);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= wws_pkg::WWS_ST_HOLD;
			cnt_q <= '0;
			good_q <= '0;
			en_q <= 1'b0;
			hold_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			good_q <= good_d;
			en_q <= en_d;
			hold_q <= hold_d;
		end
	end

	// Pin drivers; reset is open drain, enable per variant.
	assign o_supervisor_hold_n_out = 1'b0;
	assign o_supervisor_hold_n_oe = hold_q;
	assign o_enable_n_out = EN_PUSH_PULL ? ~en_q : 1'b0;
	// Open drain pulls the pin low only while enable is active
	assign o_enable_n_oe = EN_PUSH_PULL ? 1'b1 : en_q;
endmodule // wws_supervisor
`default_nettype wire

// ---- tb/wws_supervisor_properties.sv ----
// Checker: timing relations at the supervisor pins.
// Assumes one clock, with pull-ups on the open-drain pins.
`timescale 1ns/1ns
`default_nettype none
module wws_supervisor_props #(
	parameter int BASE_CYC = 400,
	parameter int REACT_CYC = 4,
	parameter bit EN_PUSH_PULL = 1'b1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_monitor_above,
	input wire logic i_watchdog_service_n,
	input wire logic o_supervisor_hold_n_out,
	input wire logic o_supervisor_hold_n_oe,
	input wire logic o_enable_n_out,
	input wire logic o_enable_n_oe
);
	localparam int CL = BASE_CYC * 4 / 5; // Closed span
	localparam int CO = BASE_CYC * 6 / 5; // Closed plus open span
	localparam int PW = BASE_CYC / 40; // Watchdog pulse width
	localparam int RB = REACT_CYC + 4; // Filter plus synchroniser slack
	int hc_q; // Cycles the hold has stood
	int sr_q; // Cycles since the last restart
	int cz_q; // Cycles since a service edge or a low monitor
	int ok_q; // Open services since the last hold
	logic sv_q; // Service pin one cycle late
	logic en_pin; // Enable pin level, pull-up when released
	logic ok_svc; // Service edge well inside the open window
	assign en_pin = o_enable_n_oe ? o_enable_n_out : 1'b1;
	assign ok_svc = sv_q && !i_watchdog_service_n && sr_q > CL + 8 && sr_q < CO - 8;
	// Reference timers; margins absorb the synchroniser lag of the design
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hc_q <= 0;
			sr_q <= 0;
			cz_q <= 0;
			ok_q <= 0;
			sv_q <= 1'b1;
		end else begin
			sv_q <= i_watchdog_service_n;
			hc_q <= o_supervisor_hold_n_oe ? hc_q + 1 : 0;
			sr_q <= (o_supervisor_hold_n_oe || ok_svc) ? 0 : sr_q + 1;
			cz_q <= (!i_monitor_above || (sv_q && !i_watchdog_service_n)) ? 0 : cz_q + 1;
			ok_q <= o_supervisor_hold_n_oe ? 0 : ok_q + int'(ok_svc);
		end
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	hold_low_a: assert property (o_supervisor_hold_n_out == 1'b0)
		else $error("hold pin drives high");
	en_off_a: assert property (o_supervisor_hold_n_oe && $past(o_supervisor_hold_n_oe) |-> en_pin)
		else $error("enable active during hold");
	drop_hold_a: assert property (!i_monitor_above [*8] |-> ##[0:RB] o_supervisor_hold_n_oe)
		else $error("no hold after voltage drop");
	hold_width_a: assert property ($fell(o_supervisor_hold_n_oe) |-> hc_q == PW || hc_q >= BASE_CYC)
		else $error("hold released after wrong span");
	closed_svc_a: assert property ($fell(i_watchdog_service_n) && sr_q > 10 && sr_q < CL - 10 && i_monitor_above |-> ##[1:12] o_supervisor_hold_n_oe)
		else $error("early service not punished");
	period_end_a: assert property (sr_q <= CO + 10)
		else $error("period ran past its end");
	rise_cause_a: assert property ($rose(o_supervisor_hold_n_oe) |-> sr_q >= CO - 2 || cz_q < 14)
		else $error("hold rose without cause");
	en_gate_a: assert property (!en_pin |-> ok_q >= 3)
		else $error("enable before three services");
endmodule // wws_supervisor_props
bind wws_supervisor wws_supervisor_props #(.BASE_CYC(BASE_CYC), .REACT_CYC(REACT_CYC),
	.EN_PUSH_PULL(EN_PUSH_PULL)) wws_supervisor_props_inst (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_monitor_above(i_monitor_above),
	.i_watchdog_service_n(i_watchdog_service_n), .o_supervisor_hold_n_out(o_supervisor_hold_n_out),
	.o_supervisor_hold_n_oe(o_supervisor_hold_n_oe), .o_enable_n_out(o_enable_n_out),
	.o_enable_n_oe(o_enable_n_oe));
`default_nettype wire

// ---- tb/wws_host.sv ----
// Host model: one clear pulse on the service pin per request.
// Assumes requests are raised for one cycle, well apart.
`timescale 1ns/1ns
`default_nettype none
module wws_host (
	input wire logic i_clk,
	input wire logic i_fire,
	output logic o_service_n
);
	int cnt = 0; // Low cycles still to drive
	// Six low cycles so the synchroniser sees a settled edge
	always @(posedge i_clk) begin
		cnt <= i_fire ? 6 : (cnt > 0 ? cnt - 1 : 0);
	end
	assign o_service_n = (cnt == 0);
endmodule // wws_host
`default_nettype wire

// ---- tb/windowed_watchdog_supervisor_bench.sv ----
// Bench: supervisor, host model, random service times and corner cases.
// Assumes a shortened base count so every span fits a short run.
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_supervisor_bench;
	localparam int BASE = 400; // Shortened base timeout
	localparam int CL = BASE * 4 / 5; // Closed span
	localparam int OW = BASE * 2 / 5; // Open span
	localparam int PW = BASE / 40; // Pulse width
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mon = 1'b0; // Comparator result
	logic fire = 1'b0; // Request to the host
	logic svc_n, hold_out, hold_oe, en_out, en_oe;
	logic en_pin; // Enable level with pull-up
	logic od_out, od_oe; // Open-drain variant enable pin
	logic od_pin; // Open-drain enable level with pull-up
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	assign en_pin = en_oe ? en_out : 1'b1;
	assign od_pin = od_oe ? od_out : 1'b1;
	always #5 clk = ~clk;
	wws_supervisor #(.BASE_CYC(BASE), .REACT_CYC(4), .EN_PUSH_PULL(1'b1)) wws_supervisor_inst (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_monitor_above(mon), .i_watchdog_service_n(svc_n),
		.o_supervisor_hold_n_out(hold_out), .o_supervisor_hold_n_oe(hold_oe),
		.o_enable_n_out(en_out), .o_enable_n_oe(en_oe));
	// Second copy in the open-drain variant, fed the same stimulus
	wws_supervisor #(.BASE_CYC(BASE), .REACT_CYC(4), .EN_PUSH_PULL(1'b0)) wws_supervisor_od_inst (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_monitor_above(mon), .i_watchdog_service_n(svc_n),
		.o_supervisor_hold_n_out(), .o_supervisor_hold_n_oe(),
		.o_enable_n_out(od_out), .o_enable_n_oe(od_oe));
	wws_host wws_host_inst (.i_clk(clk), .i_fire(fire), .o_service_n(svc_n));
	// Enable pin level after k open services
	function automatic logic exp_en(input int k);
		return (k >= 3) ? 1'b0 : 1'b1;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits d + 1 cycles, then asks the host for one pulse
	task automatic serve(input int d);
		repeat (d) @(negedge clk);
		@(negedge clk);
		fire = 1'b1;
		@(negedge clk);
		fire = 1'b0;
	endtask
	// Counts cycles until the hold reaches level v, bounded by lim
	task automatic wait_hold(input logic v, input int lim, output int k);
		k = 0;
		while (hold_oe !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'h4de5));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		serve(30);
		check(hold_oe, 1'b1);
		mon = 1'b1;
		serve(100);
		wait_hold(1'b0, BASE + 100, n);
		check(n + 102 >= BASE && n + 102 <= BASE + 16, 1'b1);
		// Open services at random points, clear of the window edges
		for (int i = 1; i <= 4; i++) begin
			serve(CL + 12 + $urandom_range(OW - 30) - (i > 1 ? 22 : 0));
			repeat (20) @(negedge clk);
			check(hold_oe, 1'b0);
			check(en_pin, exp_en(i));
			check(od_pin, exp_en(i));
		end
		serve(18 + $urandom_range(CL - 80));
		wait_hold(1'b1, 14, n);
		check(n < 14, 1'b1);
		check(en_pin, 1'b1);
		check(od_pin, 1'b1);
		wait_hold(1'b0, 40, n);
		check(n, PW);
		// Unserviced periods repeat the pulse
		for (int i = 0; i < 2; i++) begin
			wait_hold(1'b1, CL + OW + 20, n);
			check(n >= CL + OW - 3 && n <= CL + OW + 3, 1'b1);
			wait_hold(1'b0, 40, n);
			check(n, PW);
		end
		repeat (50) @(negedge clk);
		mon = 1'b0;
		wait_hold(1'b1, 20, n);
		check(n <= 10, 1'b1);
		serve(20);
		check(hold_oe, 1'b1);
		mon = 1'b1;
		wait_hold(1'b0, BASE + 40, n);
		check(n >= BASE && n <= BASE + 16, 1'b1);
		check(en_pin, 1'b1);
		conclude();
	end
endmodule // windowed_watchdog_supervisor_bench
`default_nettype wire
